// ==== src/spl_pkg.sv ====
// Purpose: Shared constants for the serial-to-parallel latch block.
// Assumes: One 40 MHz system clock; all pins sampled into that domain.
// Notes:   Pin indices describe the packed vector of sampled input pins.
`default_nettype none

package spl_pkg;

   // Register and buffer geometry
   localparam int unsigned SR_WIDTH      = 8;        // Shift and storage stages
   localparam int unsigned FIFO_DEPTH    = 8;        // Snapshot buffer words
   localparam int unsigned SYNC_STAGES   = 2;        // Flip-flops ahead of any pin logic

   // System clock
   localparam int unsigned CLK_PERIOD_NS = 25;       // 40 MHz reference clock

   // Positions of the pins inside the sampled pin vector
   localparam int unsigned PIN_COUNT     = 5;
   localparam int unsigned PIN_DATA      = 0;        // line_data_in
   localparam int unsigned PIN_SHIFT_CLK = 1;        // shift_clock
   localparam int unsigned PIN_CLEAR_N   = 2;        // shift_clear_n
   localparam int unsigned PIN_STORE_CLK = 3;        // storage clock
   localparam int unsigned PIN_OE_N      = 4;        // output enable, active low

   // Reset values
   localparam logic [PIN_COUNT-1:0] PIN_IDLE    = 5'h14;  // Clear and enable inactive
   localparam logic [SR_WIDTH-1:0]  SHIFT_RESET = 8'h00;  // Shift stages after reset
   localparam logic [SR_WIDTH-1:0]  STORE_RESET = 8'h00;  // Storage stages after reset
   localparam logic                 OE_N_RESET  = 1'h1;   // Outputs released after reset

endpackage : spl_pkg

`default_nettype wire

// ==== src/spl_stream_if.sv ====
// Purpose: Valid/ready word carrier between the latch core and its buffer.
// Assumes: Source and sink share one clock.
// Notes:   A word moves on a cycle where valid and ready are both high.
`default_nettype none

interface spl_stream_if #(
   parameter int unsigned WIDTH = spl_pkg::SR_WIDTH
);
   logic             valid;   // Source offers a word
   logic             ready;   // Sink can take a word
   logic [WIDTH-1:0] data;    // Word on offer

   // Producing side
   modport src (output valid, output data, input ready);
   // Consuming side
   modport snk (input valid, input data, output ready);
endinterface : spl_stream_if

`default_nettype wire

// ==== src/spl_fifo.sv ====
// Purpose: Small synchronous FIFO holding storage snapshots.
// Assumes: Sync active-high reset; DEPTH a power of two, at least 2.
// Notes:   Read data and both handshake outputs come from flip-flops.
`default_nettype none

module spl_fifo #(
   parameter int unsigned WIDTH = spl_pkg::SR_WIDTH,
   parameter int unsigned DEPTH = spl_pkg::FIFO_DEPTH
) (
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   spl_stream_if.snk fill,
   spl_stream_if.src drain
);

   localparam int unsigned PW = $clog2(DEPTH);       // Pointer width
   localparam int unsigned CW = $clog2(DEPTH + 1);   // Count width

   // Refuse shapes the pointer arithmetic cannot serve
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("spl_fifo: DEPTH must be a power of two of at least 2");
   end

   // All state of the buffer
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;        // Storage words
      logic [PW-1:0]               wr;         // Write pointer
      logic [PW-1:0]               rd;         // Read pointer
      logic [CW-1:0]               cnt;        // Words held in memory
      logic                        in_ready;   // Room for one more word
      logic                        out_valid;  // Output register holds a word
      logic [WIDTH-1:0]            out_data;   // Output register
   } spl_fifo_state_t;

   localparam spl_fifo_state_t FIFO_RST = '{default: '0, in_ready: 1'b1};

   spl_fifo_state_t state_reg;   // Registered state
   spl_fifo_state_t state_next;  // Next state

   logic push;  // Word accepted on the fill side
   logic load;  // Word moved from memory to the output register

   // Next-state logic
   always_comb begin
      state_next = state_reg;
      push       = fill.valid & state_reg.in_ready;
      load       = (state_reg.cnt != '0) & (~state_reg.out_valid | drain.ready);
      // Write side
      if (push) begin
         state_next.mem[state_reg.wr] = fill.data;
         state_next.wr                = PW'(state_reg.wr + 1'b1);
      end
      // Read side into the output register
      if (load) begin
         state_next.out_data  = state_reg.mem[state_reg.rd];
         state_next.out_valid = 1'b1;
         state_next.rd        = PW'(state_reg.rd + 1'b1);
      end else if (drain.ready) begin
         state_next.out_valid = 1'b0;
      end
      // Occupancy and honest full
      state_next.cnt      = CW'(state_reg.cnt + CW'(push) - CW'(load));
      state_next.in_ready = (state_next.cnt != CW'(DEPTH));
      if (srst_i) begin
         state_next = FIFO_RST;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      state_reg <= state_next;
   end

   assign fill.ready  = state_reg.in_ready;
   assign drain.valid = state_reg.out_valid;
   assign drain.data  = state_reg.out_data;

endmodule : spl_fifo

`default_nettype wire

// ==== src/spl_latch.sv ====
// Purpose: Serial-in, parallel-out shift register with storage register.
// Assumes: Pins are asynchronous to ref_clk_i and much slower than it.
// Notes:   Pin clocks are sampled; their rising edges become one-cycle events.
//
// Notes on behaviour
// - Eight shift stages load a separate storage register
// - Eight storage bits drive releasable parallel outputs
// - Shift and storage registers have separate clocks
// - Low clear forces every shift stage zero
// - Serial cascade output feeds the next device
// - High enable releases outputs; low drives storage
// - Only rising clock edges have any effect
// - Shift edge loads data, stages move up
// - Storage edge copies all shift stages
// - Common edge stores old contents, then shifts
// - Tied clocks: storage trails shift by one
`default_nettype none

module spl_latch #(
   parameter int unsigned WIDTH      = spl_pkg::SR_WIDTH,
   parameter int unsigned FIFO_DEPTH = spl_pkg::FIFO_DEPTH
) (
   input  wire logic             ref_clk_i,               // 40 MHz system clock
   input  wire logic             srst_i,                  // Sync reset, active high
   input  wire logic             line_data_in_i,          // Serial data pin
   input  wire logic             shift_clock_i,           // Shift clock pin
   input  wire logic             shift_clear_n_i,         // Shift clear pin, active low
   input  wire logic             store_clock_i,           // Storage clock pin
   input  wire logic             out_enable_n_i,          // Output enable pin, active low
   output logic [WIDTH-1:0]      parallel_outputs_o,      // Storage register contents
   output logic [WIDTH-1:0]      parallel_outputs_oe_n_o, // Low while outputs driven
   output logic                  cascade_out_o,           // Last shift stage
   output logic [WIDTH-1:0]      snap_data_o,             // Buffered storage snapshot
   output logic                  snap_valid_o,            // Snapshot on offer
   input  wire logic             snap_ready_i,            // Snapshot taken
   output logic                  snap_room_o,             // Buffer can accept a word
   output logic                  snap_overflow_o,         // A snapshot was lost
   input  wire logic             overflow_clear_i         // Clears the lost flag
);

   // Refuse widths the shift path cannot serve
   if (WIDTH < 2) begin : g_bad_width
      $error("spl_latch: WIDTH must be at least 2");
   end

   // Refuse a sampling chain of other than exactly two flip-flops
   if (spl_pkg::SYNC_STAGES != 2) begin : g_bad_sync
      $error("spl_latch: pin sampling expects exactly two stages");
   end

   localparam int unsigned PC = spl_pkg::PIN_COUNT;

   // All state of the latch core
   typedef struct packed {
      logic [PC-1:0]    pin_meta;    // First sampling stage, read only by pin_sync
      logic [PC-1:0]    pin_sync;    // Second sampling stage, safe to use
      logic             shift_prev;  // Shift clock level one cycle back
      logic             store_prev;  // Storage clock level one cycle back
      logic [WIDTH-1:0] shift;       // Serial-in shift stages
      logic [WIDTH-1:0] store;       // Parallel storage stages
      logic [WIDTH-1:0] drive_n;     // Per-bit output enable, low drives
      logic             snap_valid;  // Snapshot offered to the buffer
      logic [WIDTH-1:0] snap_data;   // Snapshot word
      logic             overflow;    // Sticky lost-snapshot flag
   } spl_state_t;

   // Reset image: pins idle, registers empty, outputs released
   localparam spl_state_t STATE_RST = '{
      pin_meta:   spl_pkg::PIN_IDLE,
      pin_sync:   spl_pkg::PIN_IDLE,
      shift_prev: 1'b0,
      store_prev: 1'b0,
      shift:      WIDTH'(spl_pkg::SHIFT_RESET),
      store:      WIDTH'(spl_pkg::STORE_RESET),
      drive_n:    {WIDTH{spl_pkg::OE_N_RESET}},
      snap_valid: 1'b0,
      snap_data:  WIDTH'(spl_pkg::STORE_RESET),
      overflow:   1'b0
   };

   spl_state_t state_reg;   // Registered state
   spl_state_t state_next;  // Next state

   // Carriers to and from the snapshot buffer
   spl_stream_if #(.WIDTH(WIDTH)) snap_fill ();
   spl_stream_if #(.WIDTH(WIDTH)) snap_drain ();

   logic [PC-1:0] pins_raw;    // Pins gathered in package order
   logic          data_s;      // Sampled serial data
   logic          clear_n_s;   // Sampled clear, active low
   logic          oe_n_s;      // Sampled output enable, active low
   logic          shift_rise;  // One-cycle shift clock rising edge
   logic          store_rise;  // One-cycle storage clock rising edge

   // Gather the asynchronous pins into one vector
   always_comb begin
      pins_raw                         = '0;
      pins_raw[spl_pkg::PIN_DATA]      = line_data_in_i;
      pins_raw[spl_pkg::PIN_SHIFT_CLK] = shift_clock_i;
      pins_raw[spl_pkg::PIN_CLEAR_N]   = shift_clear_n_i;
      pins_raw[spl_pkg::PIN_STORE_CLK] = store_clock_i;
      pins_raw[spl_pkg::PIN_OE_N]      = out_enable_n_i;
   end

   // Decode the sampled pins; only the second stage is looked at
   always_comb begin
      data_s     = state_reg.pin_sync[spl_pkg::PIN_DATA];
      clear_n_s  = state_reg.pin_sync[spl_pkg::PIN_CLEAR_N];
      oe_n_s     = state_reg.pin_sync[spl_pkg::PIN_OE_N];
      // Low-to-high only; falling edges are ignored
      shift_rise = state_reg.pin_sync[spl_pkg::PIN_SHIFT_CLK] & ~state_reg.shift_prev;
      store_rise = state_reg.pin_sync[spl_pkg::PIN_STORE_CLK] & ~state_reg.store_prev;
   end

   // Next-state logic for the whole core
   always_comb begin
      state_next = state_reg;

      // Two-stage pin sampling
      state_next.pin_meta   = pins_raw;
      state_next.pin_sync   = state_reg.pin_meta;

      // Edge history, one per pin clock, kept apart
      state_next.shift_prev = state_reg.pin_sync[spl_pkg::PIN_SHIFT_CLK];
      state_next.store_prev = state_reg.pin_sync[spl_pkg::PIN_STORE_CLK];

      // Storage stage update reads the shift stages before this cycle's shift,
      // so a common edge stores the old contents
      if (store_rise) begin
         if (clear_n_s) begin
            // Parallel copy of every stage
            state_next.store = state_reg.shift;
         end else begin
            // Shift stages are held at zero, so zero is what gets copied
            state_next.store = '0;
         end
      end
      // Otherwise the storage register simply holds, clear or not

      // Shift stage update
      if (!clear_n_s) begin
         // Clear overrides data and clock, touches nothing else
         state_next.shift = '0;
      end else if (shift_rise) begin
         // New bit into stage 0, each stage takes its neighbour
         state_next.shift = {state_reg.shift[WIDTH-2:0], data_s};
      end

      // Output enable is the same for every bit
      state_next.drive_n = {WIDTH{oe_n_s}};

      // Offer each new storage image to the buffer for one cycle
      state_next.snap_valid = store_rise;
      if (store_rise) begin
         state_next.snap_data = state_next.store;
      end

      // A snapshot offered while the buffer is full is lost; set beats clear
      if (state_reg.snap_valid && !snap_fill.ready) begin
         state_next.overflow = 1'b1;
      end else if (overflow_clear_i) begin
         state_next.overflow = 1'b0;
      end

      // Synchronous reset wins over everything
      if (srst_i) begin
         state_next = STATE_RST;
      end
   end

   // State register
   always_ff @(posedge ref_clk_i) begin
      state_reg <= state_next;
   end

   // Fill side of the snapshot buffer
   assign snap_fill.valid = state_reg.snap_valid;
   assign snap_fill.data  = state_reg.snap_data;

   // Drain side is steered by the user
   assign snap_drain.ready = snap_ready_i;

   // Snapshot buffer
   spl_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_snap_fifo (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .fill      (snap_fill.snk),
      .drain     (snap_drain.src)
   );

   // Parallel outputs straight from the storage stages
   assign parallel_outputs_o      = state_reg.store;
   // Enable low drives, high releases every bit
   assign parallel_outputs_oe_n_o = state_reg.drive_n;
   // Last shift stage, independent of the enable
   assign cascade_out_o           = state_reg.shift[WIDTH-1];

   // Buffer status and data, all from flip-flops
   assign snap_data_o     = snap_drain.data;
   assign snap_valid_o    = snap_drain.valid;
   assign snap_room_o     = snap_fill.ready;
   assign snap_overflow_o = state_reg.overflow;

endmodule : spl_latch

`default_nettype wire

// ==== dv/spl_latch_checker.sv ====
// Purpose: Port-level checks for the serial-to-parallel latch.
// Assumes: Pin effects land three reference edges after a pin change.
// Notes:   Bound to every latch instance below the module.
`default_nettype none

module spl_latch_checker #(
   parameter int unsigned WIDTH      = 8,
   parameter int unsigned FIFO_DEPTH = 8
) (
   input wire logic             ref_clk_i,
   input wire logic             srst_i,
   input wire logic             line_data_in_i,
   input wire logic             shift_clock_i,
   input wire logic             shift_clear_n_i,
   input wire logic             store_clock_i,
   input wire logic             out_enable_n_i,
   input wire logic [WIDTH-1:0] parallel_outputs_o,
   input wire logic [WIDTH-1:0] parallel_outputs_oe_n_o,
   input wire logic             cascade_out_o,
   input wire logic [WIDTH-1:0] snap_data_o,
   input wire logic             snap_valid_o,
   input wire logic             snap_ready_i,
   input wire logic             snap_room_o,
   input wire logic             snap_overflow_o,
   input wire logic             overflow_clear_i
);
   timeunit 1ns;
   timeprecision 1ps;

   // All checks run on the reference clock and rest during reset
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (srst_i);

   a_oe_follow: assert property (
      parallel_outputs_oe_n_o == {WIDTH{$past(out_enable_n_i, 3)}}) else $error("enable wrong");
   a_par_cause: assert property ($changed(parallel_outputs_o) |->
      $past(store_clock_i, 3) && !$past(store_clock_i, 4)) else $error("outputs moved");
   a_casc_cause: assert property ($changed(cascade_out_o) |->
      ($past(shift_clock_i, 3) && !$past(shift_clock_i, 4)) || !$past(shift_clear_n_i, 3))
      else $error("cascade moved");
   a_store_old: assert property ($past(store_clock_i, 3) && !$past(store_clock_i, 4) &&
      $past(shift_clear_n_i, 3) |-> parallel_outputs_o[WIDTH-1] == $past(cascade_out_o))
      else $error("storage took new stage");
   a_clear_zero: assert property (!$past(shift_clear_n_i, 3) |-> !cascade_out_o)
      else $error("clear ignored");
   a_snap_hold: assert property (snap_valid_o && !snap_ready_i |=>
      snap_valid_o && $stable(snap_data_o)) else $error("snapshot dropped");
   a_ovf_cause: assert property ($rose(snap_overflow_o) |-> !$past(snap_room_o))
      else $error("overflow with room");
   a_ovf_sticky: assert property (snap_overflow_o && !overflow_clear_i |=> snap_overflow_o)
      else $error("overflow lost");
endmodule : spl_latch_checker

bind spl_latch spl_latch_checker #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .line_data_in_i(line_data_in_i),
   .shift_clock_i(shift_clock_i), .shift_clear_n_i(shift_clear_n_i),
   .store_clock_i(store_clock_i), .out_enable_n_i(out_enable_n_i),
   .parallel_outputs_o(parallel_outputs_o), .parallel_outputs_oe_n_o(parallel_outputs_oe_n_o),
   .cascade_out_o(cascade_out_o), .snap_data_o(snap_data_o), .snap_valid_o(snap_valid_o),
   .snap_ready_i(snap_ready_i), .snap_room_o(snap_room_o),
   .snap_overflow_o(snap_overflow_o), .overflow_clear_i(overflow_clear_i));

`default_nettype wire

// ==== dv/spl_host_model.sv ====
// Purpose: Host controller that paces the latch pins.
// Assumes: Tasks are entered just after a rising reference edge.
// Notes:   Clocks stay low between pulses; data shows the inverse once hold ends.
`default_nettype none

module spl_host_model (
   input  wire logic ref_clk_i,
   output var logic  line_data_o,
   output var logic  shift_clock_o,
   output var logic  shift_clear_n_o,
   output var logic  store_clock_o,
   output var logic  out_enable_n_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle pins: clocks low, clear and enable inactive
   initial begin
      line_data_o     = 1'b0;
      shift_clock_o   = 1'b0;
      shift_clear_n_o = 1'b1;
      store_clock_o   = 1'b0;
      out_enable_n_o  = 1'b1;
   end

   // One clock pulse, four cycles of setup, high and low each
   task automatic pulse(input logic bit_v, input logic do_shift, input logic do_store);
      line_data_o <= bit_v;
      repeat (4) @(posedge ref_clk_i);
      shift_clock_o <= do_shift;
      store_clock_o <= do_store;
      repeat (4) @(posedge ref_clk_i);
      shift_clock_o <= 1'b0;
      store_clock_o <= 1'b0;
      line_data_o   <= ~bit_v;
      repeat (4) @(posedge ref_clk_i);
   endtask : pulse

   // Level pins, then time for them to take effect
   task automatic set_pins(input logic clear_n, input logic oe_n);
      shift_clear_n_o <= clear_n;
      out_enable_n_o  <= oe_n;
      repeat (5) @(posedge ref_clk_i);
   endtask : set_pins
endmodule : spl_host_model

`default_nettype wire

// ==== dv/tb_serial_to_parallel_latch.sv ====
// Purpose: Self-checking bench for the serial-to-parallel latch.
// Assumes: The host model paces every pin change by whole cycles.
// Notes:   Expected contents come from a bench-side shift model.
`default_nettype none

module tb_serial_to_parallel_latch;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned W = spl_pkg::SR_WIDTH;
   logic ref_clk_i, srst_i, sdat, sclk, sclr_n, stclk, oe_in_n;
   logic [W-1:0] par, oe_n, snap_data, sr;
   logic cascade, snap_valid, snap_ready, room, ovf, ovf_clear;
   int n_fail, comparisons, cycles;
   logic [W-1:0] exp_q[$];

   // Reference clock
   initial begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   spl_host_model host (.ref_clk_i(ref_clk_i), .line_data_o(sdat), .shift_clock_o(sclk),
      .shift_clear_n_o(sclr_n), .store_clock_o(stclk), .out_enable_n_o(oe_in_n));

   spl_latch DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .line_data_in_i(sdat),
      .shift_clock_i(sclk), .shift_clear_n_i(sclr_n), .store_clock_i(stclk),
      .out_enable_n_i(oe_in_n), .parallel_outputs_o(par), .parallel_outputs_oe_n_o(oe_n),
      .cascade_out_o(cascade), .snap_data_o(snap_data), .snap_valid_o(snap_valid),
      .snap_ready_i(snap_ready), .snap_room_o(room), .snap_overflow_o(ovf),
      .overflow_clear_i(ovf_clear));

   task automatic chk_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_word

   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {{(W-1){1'b0}}, exp}, {{(W-1){1'b0}}, got});
   endtask : chk_bit

   task automatic close_out();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // One pulse; the bench model shifts when asked and queues stored words
   task automatic step(input logic b, input logic sh, input logic st);
      logic [W-1:0] old;
      old = sr;
      if (st) exp_q.push_back(sr);
      host.pulse(b, sh, st);
      if (sh) sr = {sr[W-2:0], b};
      @(negedge ref_clk_i);
      chk_bit("cascade", sr[W-1], cascade);
      if (st) chk_word("parallel", old, par);
      // Hand back on a rising edge so the next drive lands there
      @(posedge ref_clk_i);
   endtask : step

   // Take every queued snapshot in order
   task automatic drain();
      int guard;
      guard = 0;
      snap_ready <= 1'b1;
      while (exp_q.size() > 0 && guard < 40) begin
         @(negedge ref_clk_i);
         guard++;
         if (snap_valid === 1'b1) chk_word("snapshot", exp_q.pop_front(), snap_data);
      end
      @(posedge ref_clk_i);
      snap_ready <= 1'b0;
      @(negedge ref_clk_i);
      chk_bit("queue drained", 1'b1, exp_q.size() == 0);
      chk_bit("valid after drain", 1'b0, snap_valid);
      @(posedge ref_clk_i);
   endtask : drain

   task automatic t_reset();
      chk_word("parallel", 8'h00, par);
      chk_word("enables", 8'hff, oe_n);
      chk_bit("flags", 1'b1, !cascade && !snap_valid && room && !ovf);
   endtask : t_reset

   task automatic t_shift_store();
      logic [W-1:0] pat;  // Word sent most significant bit first
      pat = 8'hb4;
      for (int i = W - 1; i >= 0; i--) step(pat[i], 1'b1, 1'b0);
      step(1'b0, 1'b0, 1'b1);
      chk_word("stored image", 8'hb4, par);
      drain();
   endtask : t_shift_store

   task automatic t_enable();
      host.set_pins(1'b1, 1'b0);
      chk_word("enables on", 8'h00, oe_n);
      chk_bit("cascade kept", 1'b1, cascade);
      host.set_pins(1'b1, 1'b1);
      chk_word("enables off", 8'hff, oe_n);
   endtask : t_enable

   task automatic t_clear();
      host.set_pins(1'b0, 1'b1);
      chk_bit("cascade cleared", 1'b0, cascade);
      chk_word("storage kept", 8'hb4, par);
      host.pulse(1'b1, 1'b1, 1'b0);
      sr = 8'h00;
      // Storage edge while clear is low copies the zeroed stages
      step(1'b1, 1'b0, 1'b1);
      host.set_pins(1'b1, 1'b1);
      step(1'b0, 1'b0, 1'b1);
      drain();
   endtask : t_clear

   // Tied clocks until the buffer refuses, then overflow and drain
   task automatic t_tied_fill();
      for (int i = 0; i < 10; i++) begin
         step(~i[0], 1'b1, 1'b1);
         if (i == 8) chk_bit("room when full", 1'b0, room);
      end
      void'(exp_q.pop_back());
      chk_bit("overflow", 1'b1, ovf);
      ovf_clear <= 1'b1;
      @(posedge ref_clk_i);
      ovf_clear <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      chk_bit("overflow cleared", 1'b0, ovf);
      drain();
   endtask : t_tied_fill

   // Hang guard
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_fail++;
         close_out();
      end
   end

   initial begin
      n_fail = 0;
      comparisons = 0;
      cycles = 0;
      sr = 8'h00;
      srst_i = 1'b1;
      snap_ready = 1'b0;
      ovf_clear = 1'b0;
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      t_reset();
      t_shift_store();
      t_enable();
      t_clear();
      t_tied_fill();
      close_out();
   end
endmodule : tb_serial_to_parallel_latch

`default_nettype wire
